// ### inc/jtag_port_pkg.sv
/*
 * shared constants, state codes and pin bundles of the scan test port.
 * assumes a system clock far faster than the test clock it samples.
 */
package jtag_port_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'hF,
        RUN_TEST_IDLE    = 4'hC,
        SELECT_DR_SCAN   = 4'h7,
        CAPTURE_DR       = 4'h6,
        SHIFT_DR         = 4'h2,
        EXIT1_DR         = 4'h1,
        PAUSE_DR         = 4'h3,
        EXIT2_DR         = 4'h0,
        UPDATE_DR        = 4'h5,
        SELECT_IR_SCAN   = 4'h4,
        CAPTURE_IR       = 4'hE,
        SHIFT_IR         = 4'hA,
        EXIT1_IR         = 4'h9,
        PAUSE_IR         = 4'hB,
        EXIT2_IR         = 4'h8,
        UPDATE_IR        = 4'hD
    } tap_state_e;

    localparam int          IR_WIDTH      = 4;
    localparam logic [3:0]  IR_BYPASS     = 4'hF;
    localparam logic [3:0]  IR_EMU_CFG    = 4'h8;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam int          EMU_CFG_WIDTH = 4;
    localparam logic [3:0]  EMU_CFG_RESET = 4'h0;
    localparam int          CFG_DIR_A     = 0;
    localparam int          CFG_DIR_B     = 1;
    localparam int          CFG_LVL_A     = 2;
    localparam int          CFG_LVL_B     = 3;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst;
    } scan_in_s;

    typedef struct packed {
        logic emu_a;
        logic emu_b;
    } emu_pins_s;

endpackage : jtag_port_pkg

// ### hdl/pin_sync.sv
/*
 * two-flip-flop synchroniser for a bundle of pin levels.
 * assumes the pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : pin_sync

// ### hdl/jtag_emulation_test_port.sv
/*
 * scan test and emulation port: tap controller, instruction register,
 * bypass and emulator-configuration data registers, event lines, and
 * the output-disable detect.
 * assumes tck is at least four sys_clk periods per phase; pins arrive
 * asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
module jtag_emulation_test_port #(
    parameter int IR_W  = jtag_port_pkg::IR_WIDTH,
    parameter int CFG_W = jtag_port_pkg::EMU_CFG_WIDTH
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    input  wire jtag_port_pkg::scan_in_s scan_in,
    input  wire jtag_port_pkg::emu_pins_s emu_in,
    input  wire logic [1:0]             core_event,
    output logic                        tdo,
    output logic                        tdo_oe,
    output jtag_port_pkg::emu_pins_s    emu_out,
    output jtag_port_pkg::emu_pins_s    emu_oe,
    output logic [1:0]                  emu_event,
    output logic                        outputs_disable_n,
    output logic                        scan_active,
    output logic [3:0]                  tap_state
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] pins_sync;

    pin_sync #(.WIDTH(6)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({scan_in, emu_in}),
        .sync_out (pins_sync)
    );

    logic tck_s, tms_s, tdi_s, trst_s, emu_a_s, emu_b_s;
    assign {tck_s, tms_s, tdi_s, trst_s, emu_a_s, emu_b_s} = pins_sync;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    jtag_port_pkg::tap_state_e state, next_state;
    logic             tck_d, next_tck_d;
    logic [IR_W-1:0]  ir, next_ir, ir_sh, next_ir_sh;
    logic [CFG_W-1:0] cfg, next_cfg, cfg_sh, next_cfg_sh;
    logic             byp, next_byp;
    logic             tdo_q, next_tdo_q;
    logic             tdo_oe_q, next_tdo_oe_q, next_tdo_oe;
    logic             off_n, next_off_n;
    jtag_port_pkg::emu_pins_s eo, next_eo, eoe, next_eoe, next_emu_out;
    logic [1:0]       ev, next_ev, next_emu_event;

    logic rise, fall, scan_mode;
    assign rise      = tck_s & ~tck_d;
    assign fall      = ~tck_s & tck_d;
    assign scan_mode = trst_s;

    function automatic jtag_port_pkg::tap_state_e tap_next(
        input jtag_port_pkg::tap_state_e s,
        input logic                      m
    );
        case (s)
            jtag_port_pkg::TEST_LOGIC_RESET:
                tap_next = m ? jtag_port_pkg::TEST_LOGIC_RESET
                             : jtag_port_pkg::RUN_TEST_IDLE;
            jtag_port_pkg::RUN_TEST_IDLE:
                tap_next = m ? jtag_port_pkg::SELECT_DR_SCAN
                             : jtag_port_pkg::RUN_TEST_IDLE;
            jtag_port_pkg::SELECT_DR_SCAN:
                tap_next = m ? jtag_port_pkg::SELECT_IR_SCAN
                             : jtag_port_pkg::CAPTURE_DR;
            jtag_port_pkg::CAPTURE_DR, jtag_port_pkg::SHIFT_DR:
                tap_next = m ? jtag_port_pkg::EXIT1_DR
                             : jtag_port_pkg::SHIFT_DR;
            jtag_port_pkg::EXIT1_DR:
                tap_next = m ? jtag_port_pkg::UPDATE_DR
                             : jtag_port_pkg::PAUSE_DR;
            jtag_port_pkg::PAUSE_DR:
                tap_next = m ? jtag_port_pkg::EXIT2_DR
                             : jtag_port_pkg::PAUSE_DR;
            jtag_port_pkg::EXIT2_DR:
                tap_next = m ? jtag_port_pkg::UPDATE_DR
                             : jtag_port_pkg::SHIFT_DR;
            jtag_port_pkg::UPDATE_DR, jtag_port_pkg::UPDATE_IR:
                tap_next = m ? jtag_port_pkg::SELECT_DR_SCAN
                             : jtag_port_pkg::RUN_TEST_IDLE;
            jtag_port_pkg::SELECT_IR_SCAN:
                tap_next = m ? jtag_port_pkg::TEST_LOGIC_RESET
                             : jtag_port_pkg::CAPTURE_IR;
            jtag_port_pkg::CAPTURE_IR, jtag_port_pkg::SHIFT_IR:
                tap_next = m ? jtag_port_pkg::EXIT1_IR
                             : jtag_port_pkg::SHIFT_IR;
            jtag_port_pkg::EXIT1_IR:
                tap_next = m ? jtag_port_pkg::UPDATE_IR
                             : jtag_port_pkg::PAUSE_IR;
            jtag_port_pkg::PAUSE_IR:
                tap_next = m ? jtag_port_pkg::EXIT2_IR
                             : jtag_port_pkg::PAUSE_IR;
            jtag_port_pkg::EXIT2_IR:
                tap_next = m ? jtag_port_pkg::UPDATE_IR
                             : jtag_port_pkg::SHIFT_IR;
            default:
                tap_next = jtag_port_pkg::TEST_LOGIC_RESET;
        endcase
    endfunction : tap_next

    // ----------------------------------------------------------------
    // next-value logic
    // ----------------------------------------------------------------
    always_comb begin
        next_tck_d    = tck_s;
        next_state    = state;
        next_ir       = ir;
        next_ir_sh    = ir_sh;
        next_cfg      = cfg;
        next_cfg_sh   = cfg_sh;
        next_byp      = byp;
        next_tdo_q    = tdo_q;
        next_tdo_oe_q = tdo_oe_q;
        next_ev       = {emu_b_s, emu_a_s};
        // disable: reset low, line a high, line b low
        next_off_n    = ~(~trst_s & emu_a_s & ~emu_b_s);
        if (!scan_mode) begin
            // functional mode: scan ignored, controller held reset
            next_state = jtag_port_pkg::TEST_LOGIC_RESET;
            next_ir    = jtag_port_pkg::IR_BYPASS;
            next_cfg   = jtag_port_pkg::EMU_CFG_RESET;
            next_tdo_oe_q = 1'b0;
        end else if (rise) begin
            next_state = tap_next(state, tms_s);
            case (state)
                jtag_port_pkg::TEST_LOGIC_RESET: begin
                    next_ir  = jtag_port_pkg::IR_BYPASS;
                    next_cfg = jtag_port_pkg::EMU_CFG_RESET;
                end
                jtag_port_pkg::CAPTURE_IR:
                    next_ir_sh = IR_W'(jtag_port_pkg::IR_CAPTURE);
                jtag_port_pkg::SHIFT_IR:
                    next_ir_sh = {tdi_s, ir_sh[IR_W-1:1]};
                jtag_port_pkg::UPDATE_IR:
                    next_ir = ir_sh;
                jtag_port_pkg::CAPTURE_DR: begin
                    next_byp    = 1'b0;
                    next_cfg_sh = cfg;
                end
                jtag_port_pkg::SHIFT_DR: begin
                    if (ir == jtag_port_pkg::IR_EMU_CFG)
                        next_cfg_sh = {tdi_s, cfg_sh[CFG_W-1:1]};
                    else
                        next_byp = tdi_s;
                end
                jtag_port_pkg::UPDATE_DR: begin
                    if (ir == jtag_port_pkg::IR_EMU_CFG)
                        next_cfg = cfg_sh;
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            // output moves only on the falling edge
            if (state == jtag_port_pkg::SHIFT_IR) begin
                next_tdo_q    = ir_sh[0];
                next_tdo_oe_q = 1'b1;
            end else if (state == jtag_port_pkg::SHIFT_DR) begin
                next_tdo_q    = (ir == jtag_port_pkg::IR_EMU_CFG)
                                ? cfg_sh[0] : byp;
                next_tdo_oe_q = 1'b1;
            end else begin
                next_tdo_oe_q = 1'b0;
            end
        end
        // event lines: direction and drive level from cfg, with core_event[1] ORed into the line b level
        next_eo.emu_a  = cfg[jtag_port_pkg::CFG_LVL_A];
        next_eo.emu_b  = cfg[jtag_port_pkg::CFG_LVL_B];
        next_eoe.emu_a = scan_mode & cfg[jtag_port_pkg::CFG_DIR_A];
        next_eoe.emu_b = scan_mode & cfg[jtag_port_pkg::CFG_DIR_B];
        next_tdo_oe    = tdo_oe_q & next_off_n;
        next_emu_out   = eo | {1'b0, core_event[1]};
        next_emu_event = ev & {2{scan_mode}};
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_d    <= 1'b0;
            state    <= jtag_port_pkg::TEST_LOGIC_RESET;
            ir       <= jtag_port_pkg::IR_BYPASS;
            ir_sh    <= '0;
            cfg      <= jtag_port_pkg::EMU_CFG_RESET;
            cfg_sh   <= '0;
            byp      <= 1'b0;
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
            off_n    <= 1'b1;
            eo       <= '0;
            eoe      <= '0;
            ev       <= '0;
        end else begin
            tck_d    <= next_tck_d;
            state    <= next_state;
            ir       <= next_ir;
            ir_sh    <= next_ir_sh;
            cfg      <= next_cfg;
            cfg_sh   <= next_cfg_sh;
            byp      <= next_byp;
            tdo_q    <= next_tdo_q;
            tdo_oe_q <= next_tdo_oe_q;
            off_n    <= next_off_n;
            eo       <= next_eo;
            eoe      <= next_eoe;
            ev       <= next_ev;
        end
    end

    // ----------------------------------------------------------------
    // output stage
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo               <= 1'b0;
            tdo_oe            <= 1'b0;
            emu_out           <= '0;
            emu_oe            <= '0;
            emu_event         <= '0;
            outputs_disable_n <= 1'b1;
            scan_active       <= 1'b0;
            tap_state         <= jtag_port_pkg::TEST_LOGIC_RESET;
        end else begin
            tdo               <= tdo_q;
            tdo_oe            <= next_tdo_oe;
            emu_out           <= next_emu_out;
            emu_oe            <= eoe;
            emu_event         <= next_emu_event;
            outputs_disable_n <= off_n;
            scan_active       <= scan_mode;
            tap_state         <= state;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_TDO_FLOATS_OFF: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !off_n |=> !tdo_oe)
        else $error("tdo driven while output-disable active");
    AST_TDO_ON_FALL: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $changed(tdo_q) |-> $past(fall))
        else $error("tdo changed away from a falling edge");
    AST_RESET_IN_FUNC: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !trst_s |=>
        state == jtag_port_pkg::TEST_LOGIC_RESET)
        else $error("controller moved outside scan mode");
    AST_STATE_ON_RISE: assert property (@(posedge sys_clk)
        disable iff (!reset_n) trst_s && !rise |=> $stable(state))
        else $error("state moved without a rising edge");
    AST_TMS_HOLDS_RESET: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        rise && tms_s && state == jtag_port_pkg::TEST_LOGIC_RESET |=>
        state == jtag_port_pkg::TEST_LOGIC_RESET)
        else $error("tms high did not hold test-logic-reset");
    AST_IDLE_STEP: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        trst_s && rise && !tms_s && state == jtag_port_pkg::UPDATE_DR |=>
        state == jtag_port_pkg::RUN_TEST_IDLE)
        else $error("update did not return to idle");
    AST_EMU_A_DIR: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !trst_s |=> ##1 !emu_oe.emu_a)
        else $error("event line a driven in functional mode");
    AST_OFF_DETECT: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !trst_s && emu_a_s && !emu_b_s |=>
        ##1 !outputs_disable_n)
        else $error("disable condition not reported");
endmodule : jtag_emulation_test_port

// ### dv/jtag_host_model.sv
/*
 * behavioural scan host: drives the test pins and the emulator lines.
 * assumes the device drives an event line only where its enable is high;
 * undriven event lines are pulled up.
 */
`timescale 1ns/1ps
module jtag_host_model (
    input  wire jtag_port_pkg::emu_pins_s dev_out,
    input  wire jtag_port_pkg::emu_pins_s dev_oe,
    output jtag_port_pkg::scan_in_s       scan_in,
    output jtag_port_pkg::emu_pins_s      emu_wire
);
    localparam time HALF = 400;
    logic [1:0] host_lvl;
    logic [1:0] host_oe;

    // wire level: device, else host, else pull-up
    assign emu_wire = (dev_oe & dev_out) | (~dev_oe & host_oe & host_lvl)
                    | (~dev_oe & ~host_oe);

    initial begin
        scan_in  = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst: 1'b0};
        host_lvl = 2'h0;
        host_oe  = 2'h0;
    end

    // one test clock period, clock idles low outside frames
    task automatic clock_bit(input logic tms, input logic tdi);
        scan_in.tms = tms;
        scan_in.tdi = tdi;
        #(HALF) scan_in.tck = 1'b1;
        #(HALF) scan_in.tck = 1'b0;
    endtask : clock_bit

    task automatic set_trst(input logic v);
        scan_in.trst = v;
    endtask : set_trst

    // hold test reset low and drive both event lines (a, b)
    task automatic drive_lines(input logic [1:0] lvl, input logic on);
        scan_in.trst = 1'b0;
        host_lvl     = lvl;
        host_oe      = {on, on};
    endtask : drive_lines
endmodule : jtag_host_model

// ### dv/testbench.sv
/*
 * self-checking bench of the scan test port with a host model.
 * assumes test clock phases of 400 ns against a 100 ns system clock.
 */
`timescale 1ns/1ps
module testbench;
    logic                     sys_clk;
    logic                     reset_n;
    logic [1:0]               core_event;
    jtag_port_pkg::scan_in_s  scan_in;
    jtag_port_pkg::emu_pins_s emu_in;
    jtag_port_pkg::emu_pins_s emu_out;
    jtag_port_pkg::emu_pins_s emu_oe;
    logic                     tdo;
    logic                     tdo_oe;
    logic                     outputs_disable_n;
    logic                     scan_active;
    logic [1:0]               emu_event;
    logic [3:0]               tap_state;
    logic                     tdo_hi;
    logic [3:0]               cfg;
    logic                     tdo_exp[$];
    int                       err_total;
    int                       n_checks;
    int                       seed;

    jtag_emulation_test_port i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .scan_in(scan_in),
        .emu_in(emu_in), .core_event(core_event), .tdo(tdo),
        .tdo_oe(tdo_oe), .emu_out(emu_out), .emu_oe(emu_oe),
        .emu_event(emu_event), .outputs_disable_n(outputs_disable_n),
        .scan_active(scan_active), .tap_state(tap_state)
    );

    jtag_host_model i_host (
        .dev_out(emu_out), .dev_oe(emu_oe), .scan_in(scan_in),
        .emu_wire(emu_in)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [3:0] seen,
                         input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic step(input logic tms, input logic tdi, input logic [3:0] e);
        i_host.clock_bit(tms, tdi);
        check("tap_state", tap_state, e);
    endtask : step

    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #5;
    endtask : settle

    // ----------------------------------------
    // output watcher
    // ----------------------------------------
    always @(posedge scan_in.tck) tdo_hi = tdo;
    always @(negedge scan_in.tck) begin
        if (tdo_oe === 1'b1 && tdo_exp.size() > 0) begin
            check("tdo", {3'h0, tdo}, {3'h0, tdo_exp.pop_front()});
            check("tdo_hold", {3'h0, tdo}, {3'h0, tdo_hi});
        end
    end

    initial begin
        #200_000;
        err_total++;
        end_of_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed       = 68488;
        err_total  = 0;
        n_checks   = 0;
        reset_n    = 1'b0;
        core_event = 2'h0;
        repeat (16) @(posedge sys_clk);
        #5;
        reset_n    = 1'b1;
        core_event = 2'($random(seed));
        check("tap_state", tap_state, 4'hF);
        check("disable_n", {3'h0, outputs_disable_n}, 4'h1);
        repeat (3) i_host.clock_bit(1'b0, 1'b0);
        check("tap_state", tap_state, 4'hF);
        check("emu_event", {2'h0, emu_event}, 4'h0);
        check("tdo_oe", {3'h0, tdo_oe}, 4'h0);
        $display("test ignore done");

        i_host.set_trst(1'b1);
        settle();
        check("scan_active", {3'h0, scan_active}, 4'h1);
        check("emu_event", {2'h0, emu_event}, 4'h3);
        step(1'b1, 1'b0, 4'hF);
        step(1'b0, 1'b0, 4'hC);
        step(1'b1, 1'b0, 4'h7);
        step(1'b1, 1'b0, 4'h4);
        step(1'b0, 1'b0, 4'hE);
        step(1'b0, 1'b0, 4'hA);
        for (int i = 0; i < 4; i++) begin
            tdo_exp.push_back(jtag_port_pkg::IR_CAPTURE[i]);
        end
        for (int i = 0; i < 4; i++) begin
            step(i == 3, i == 3, (i == 3) ? 4'h9 : 4'hA);
        end
        step(1'b1, 1'b0, 4'hD);
        step(1'b0, 1'b0, 4'hC);
        check("tdo_left", 4'(tdo_exp.size()), 4'h0);
        $display("test instruction shift done");

        cfg = 4'h0;
        for (int k = 0; k < 3; k++) begin
            // captured value of the previous update shifts out
            for (int i = 0; i < 4; i++) begin
                tdo_exp.push_back(cfg[i]);
            end
            cfg = 4'($random(seed));
            step(1'b1, 1'b0, 4'h7);
            step(1'b0, 1'b0, 4'h6);
            step(1'b0, 1'b0, 4'h2);
            for (int i = 0; i < 4; i++) begin
                step(i == 3, cfg[i], (i == 3) ? 4'h1 : 4'h2);
            end
            step(1'b1, 1'b0, 4'h5);
            step(1'b0, 1'b0, 4'hC);
            settle();
            check("emu_oe", {2'h0, emu_oe}, {2'h0, cfg[0], cfg[1]});
            check("emu_out", {2'h0, emu_out},
                  {2'h0, cfg[2], cfg[3] | core_event[1]});
        end
        check("tdo_left", 4'(tdo_exp.size()), 4'h0);
        $display("test event config done");

        i_host.drive_lines(2'b10, 1'b1);
        settle();
        check("disable_n", {3'h0, outputs_disable_n}, 4'h0);
        check("tdo_oe", {3'h0, tdo_oe}, 4'h0);
        check("emu_oe", {2'h0, emu_oe}, 4'h0);
        check("tap_state", tap_state, 4'hF);
        i_host.drive_lines(2'b00, 1'b1);
        settle();
        check("disable_n", {3'h0, outputs_disable_n}, 4'h1);
        i_host.drive_lines(2'b10, 1'b0);
        settle();
        check("disable_n", {3'h0, outputs_disable_n}, 4'h1);
        $display("test output disable done");
        end_of_test();
    end
endmodule : testbench
